// ---- backplane_slot_decode_irq.sv ----
`timescale 1ns/10ps
module backplane_slot_decode_irq (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [3:0]  unitSelect,
  input  wire logic        addressStrobe,
  input  wire logic        dataStrobeLine,
  input  wire logic        writeCycle,
  input  wire logic        cardResponse,
  input  wire logic [7:0]  slotInterruptIn,
  input  wire logic [15:0] upstreamDataIn,
  output logic      [15:0] upstreamDataOut,
  output logic             upstreamDataOe,
  input  wire logic [15:0] cardSideDataIn,
  output logic      [15:0] cardSideDataOut,
  output logic             cardSideDataOe,
  output logic             upstreamResponse,
  output logic      [7:0]  slotEnable,
  output logic      [7:0]  registerSelect,
  output logic             functionInterruptRequest
);

  backplane_pkg::state_s  q;
  backplane_pkg::state_s  n;
  backplane_pkg::pin_in_s pins;

  function automatic logic [3:0] unitOf(input logic [14:0] a);
    unitOf = a[backplane_pkg::UNIT_HI:backplane_pkg::UNIT_LO];
  endfunction : unitOf

  function automatic logic [2:0] slotOf(input logic [14:0] a);
    slotOf = a[backplane_pkg::SLOT_HI:backplane_pkg::SLOT_LO];
  endfunction : slotOf

  function automatic logic [7:0] regOf(input logic [14:0] a);
    regOf = a[backplane_pkg::REG_HI:backplane_pkg::REG_LO];
  endfunction : regOf

  function automatic logic [7:0] slotDecode(input logic [2:0] s);
    slotDecode = 8'h01 << s;
  endfunction : slotDecode

  logic unitMatch;
  logic isStatus;

  always_comb begin
    pins.addrStrobe   = addressStrobe;
    pins.dataStrobe   = dataStrobeLine;
    pins.writeCycle   = writeCycle;
    pins.cardResponse = cardResponse;
    pins.slotIrq      = slotInterruptIn;
    pins.unitNumber   = unitSelect;
    pins.upstreamData = upstreamDataIn;
    pins.cardSideData = cardSideDataIn;
  end

  assign unitMatch = (unitOf(q.addr) == q.s2.unitNumber);
  assign isStatus  = (regOf(q.addr) == backplane_pkg::STATUS_REG);

  always_comb begin
    n    = q;
    // every pin but clk, rst_b and ce passes two flops, so the status word never reads a moving line
    n.s1 = pins;
    n.s2 = q.s1;
    n.pending = q.s2.slotIrq & q.unmask;
    n.irqReq  = |n.pending;
    unique case (q.phase)
      backplane_pkg::PH_IDLE,
      backplane_pkg::PH_CARD,
      backplane_pkg::PH_STAT: begin
        if (q.s2.addrStrobe) begin
          // enable held until here, the start of the next address phase
          n.phase      = backplane_pkg::PH_ADDR;
          n.slotEnable = '0;
          n.upOe       = 1'b0;
          n.cardOe     = 1'b0;
          n.upResp     = 1'b0;
        end else if (q.phase == backplane_pkg::PH_CARD) begin
          n.upResp = q.s2.cardResponse & q.s2.dataStrobe;
          n.upOe   = 1'b0;
          n.cardOe = 1'b0;
          if (q.s2.dataStrobe && q.s2.writeCycle) begin
            n.cardOut = q.s2.upstreamData;
            n.cardOe  = 1'b1;
          end else if (q.s2.dataStrobe) begin
            n.upOut = q.s2.cardSideData;
            n.upOe  = 1'b1;
          end
        end else if (q.phase == backplane_pkg::PH_STAT) begin
          n.slotEnable = '0;
          n.upOe       = 1'b0;
          n.upResp     = q.s2.dataStrobe;
          if (q.s2.dataStrobe && q.s2.writeCycle) begin
            n.unmask = q.s2.upstreamData[7:0];
          end else if (q.s2.dataStrobe) begin
            n.upOut = {n.unmask, n.pending};
            n.upOe  = 1'b1;
          end
        end
      end
      backplane_pkg::PH_ADDR: begin
        if (q.s2.addrStrobe) begin
          n.addr           = q.s2.upstreamData[14:0];
          n.registerSelect = regOf(n.addr);
        end else if (!unitMatch) begin
          n.phase = backplane_pkg::PH_IDLE;
        end else if (isStatus) begin
          n.phase = backplane_pkg::PH_STAT;
        end else begin
          n.phase      = backplane_pkg::PH_CARD;
          n.slotEnable = slotDecode(slotOf(q.addr));
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= backplane_pkg::STATE_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  assign upstreamDataOut          = q.upOut;
  assign upstreamDataOe           = q.upOe;
  assign cardSideDataOut          = q.cardOut;
  assign cardSideDataOe           = q.cardOe;
  assign upstreamResponse         = q.upResp;
  assign slotEnable               = q.slotEnable;
  assign registerSelect           = q.registerSelect;
  assign functionInterruptRequest = q.irqReq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  enable_one_hot_a: assert property ($onehot0(q.slotEnable))
    else $error("more than one slot enable active");

  status_no_card_a: assert property (q.phase == backplane_pkg::PH_STAT |-> q.slotEnable == '0)
    else $error("card enabled during status access");

  pending_tracks_a: assert property (ce |=> q.pending == $past(q.s2.slotIrq & q.unmask))
    else $error("pending bits do not follow masked inputs");

  irq_request_a: assert property (q.irqReq == (q.pending != '0))
    else $error("interrupt request disagrees with pending bits");

  status_word_a: assert property (q.phase == backplane_pkg::PH_STAT && q.upOe |->
      q.upOut == {q.unmask, q.pending})
    else $error("status word wrong");

  status_card_response_a: assert property (ce && q.phase == backplane_pkg::PH_STAT && !q.s2.addrStrobe
      && q.s2.dataStrobe |=> q.upResp)
    else $error("no response on status access");

  enable_raise_a: assert property (ce && q.phase == backplane_pkg::PH_ADDR && !q.s2.addrStrobe
      && unitMatch && !isStatus |=> q.slotEnable == slotDecode(slotOf($past(q.addr))))
    else $error("slot enable not raised at strobe fall");

  enable_hold_a: assert property (ce && q.phase == backplane_pkg::PH_CARD && !q.s2.addrStrobe
      |=> $stable(q.slotEnable))
    else $error("slot enable dropped before next address");

  unit_miss_a: assert property (ce && q.phase == backplane_pkg::PH_ADDR && !q.s2.addrStrobe
      && !unitMatch |=> q.slotEnable == '0 ##1 q.slotEnable == '0 || !ce)
    else $error("slot enabled for another unit");

  miss_idle_a: assert property (ce && q.phase == backplane_pkg::PH_ADDR && !q.s2.addrStrobe
      && !unitMatch |=> q.phase == backplane_pkg::PH_IDLE)
    else $error("foreign unit did not return to idle");

  idle_stay_a: assert property (ce && q.phase == backplane_pkg::PH_IDLE
      && !q.s2.addrStrobe |=> q.phase == backplane_pkg::PH_IDLE)
    else $error("idle left without address strobe");

  idle_no_drive_a: assert property (q.phase == backplane_pkg::PH_IDLE |->
      !q.upOe && !q.cardOe && !q.upResp && q.slotEnable == '0)
    else $error("outputs active while idle");

  addr_no_drive_a: assert property (q.phase == backplane_pkg::PH_ADDR |->
      !q.upOe && !q.cardOe && !q.upResp && q.slotEnable == '0)
    else $error("outputs active during address phase");

  strobe_start_a: assert property (ce && q.phase != backplane_pkg::PH_ADDR
      && q.s2.addrStrobe |=> q.phase == backplane_pkg::PH_ADDR)
    else $error("address strobe did not open address phase");

  card_enable_a: assert property (q.phase == backplane_pkg::PH_CARD |->
      $onehot(q.slotEnable))
    else $error("card phase without one slot enable");

  enable_phase_a: assert property (q.slotEnable != '0 |->
      q.phase == backplane_pkg::PH_CARD)
    else $error("slot enable outside card phase");

  addr_latch_a: assert property (ce && q.phase == backplane_pkg::PH_ADDR
      && q.s2.addrStrobe |=> q.addr == $past(q.s2.upstreamData[14:0]))
    else $error("address not latched");

  regsel_latch_a: assert property (ce && q.phase == backplane_pkg::PH_ADDR
      && q.s2.addrStrobe |=> q.registerSelect == $past(q.s2.upstreamData[7:0]))
    else $error("register select not latched");

  addr_hold_a: assert property (ce && !(q.phase == backplane_pkg::PH_ADDR
      && q.s2.addrStrobe) |=> $stable(q.addr))
    else $error("address latch changed outside address phase");

  oe_exclusive_a: assert property (!(q.upOe && q.cardOe))
    else $error("both data sides driven");

  card_oe_phase_a: assert property (q.cardOe |-> q.phase == backplane_pkg::PH_CARD)
    else $error("card side driven outside card phase");

  up_oe_phase_a: assert property (q.upOe |-> q.phase == backplane_pkg::PH_CARD
      || q.phase == backplane_pkg::PH_STAT)
    else $error("master side driven outside data phase");

  write_path_a: assert property (ce && q.phase == backplane_pkg::PH_CARD && !q.s2.addrStrobe
      && q.s2.dataStrobe && q.s2.writeCycle |=> q.cardOe
      && q.cardOut == $past(q.s2.upstreamData))
    else $error("write data not passed to cards");

  read_path_a: assert property (ce && q.phase == backplane_pkg::PH_CARD && !q.s2.addrStrobe
      && q.s2.dataStrobe && !q.s2.writeCycle |=> q.upOe
      && q.upOut == $past(q.s2.cardSideData))
    else $error("read data not passed to master");

  card_drop_a: assert property (ce && q.phase == backplane_pkg::PH_CARD && !q.s2.addrStrobe
      && !q.s2.dataStrobe |=> !q.upOe && !q.cardOe && !q.upResp)
    else $error("card transfer outputs stayed after strobe");

  card_card_response_a: assert property (ce && q.phase == backplane_pkg::PH_CARD
      && !q.s2.addrStrobe |=> q.upResp == $past(q.s2.cardResponse && q.s2.dataStrobe))
    else $error("card response not passed to master");

  unmask_write_a: assert property (ce && q.phase == backplane_pkg::PH_STAT
      && !q.s2.addrStrobe && q.s2.dataStrobe && q.s2.writeCycle
      |=> q.unmask == $past(q.s2.upstreamData[7:0]))
    else $error("unmask write lost");

  unmask_hold_a: assert property (ce && !(q.phase == backplane_pkg::PH_STAT
      && !q.s2.addrStrobe && q.s2.dataStrobe && q.s2.writeCycle) |=> $stable(q.unmask))
    else $error("unmask changed without write");

  status_enter_a: assert property (ce && q.phase == backplane_pkg::PH_ADDR
      && !q.s2.addrStrobe && unitMatch && isStatus |=> q.phase == backplane_pkg::PH_STAT)
    else $error("status access not recognised");

  status_card_oe_a: assert property (q.phase == backplane_pkg::PH_STAT |-> !q.cardOe)
    else $error("card side driven during status access");

  status_oe_a: assert property (ce && q.phase == backplane_pkg::PH_STAT
      && !q.s2.addrStrobe && q.s2.dataStrobe && !q.s2.writeCycle |=> q.upOe)
    else $error("status word not driven");

  status_data_a: assert property (ce && q.phase == backplane_pkg::PH_STAT
      && !q.s2.addrStrobe && q.s2.dataStrobe && !q.s2.writeCycle
      |=> q.upOut == {$past(q.unmask), $past(q.s2.slotIrq & q.unmask)})
    else $error("status word bits misplaced");

  status_drop_a: assert property (ce && q.phase == backplane_pkg::PH_STAT
      && !q.s2.addrStrobe && !q.s2.dataStrobe |=> !q.upResp && !q.upOe)
    else $error("status response stayed after strobe");

  card_response_phase_a: assert property (q.upResp |-> q.phase == backplane_pkg::PH_CARD
      || q.phase == backplane_pkg::PH_STAT)
    else $error("response outside data phase");

  sync_stage_a: assert property (ce |=> q.s2 == $past(q.s1))
    else $error("second sync stage skipped");

  // a frozen block must not drift, or a held bus cycle would resume mid-step
  freeze_a: assert property (!ce |=> $stable(q))
    else $error("state moved while clock enable low");

  request_idle_a: assert property (q.pending == '0 |-> !q.irqReq)
    else $error("request without pending bits");

endmodule : backplane_slot_decode_irq

// ---- backplane_pkg.sv ----
package backplane_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SLOTS         = 8;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned ADDR_W        = 15;

  localparam int unsigned UNIT_HI = 14;
  localparam int unsigned UNIT_LO = 11;
  localparam int unsigned SLOT_HI = 10;
  localparam int unsigned SLOT_LO = 8;
  localparam int unsigned REG_HI  = 7;
  localparam int unsigned REG_LO  = 0;

  localparam logic [7:0] STATUS_REG = 8'hFF;
  localparam logic [7:0] UNMASK_RST = 8'h00;

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_ADDR = 4'h2,
    PH_CARD = 4'h4,
    PH_STAT = 4'h8
  } phase_e;

  typedef struct packed {
    logic              addrStrobe;
    logic              dataStrobe;
    logic              writeCycle;
    logic              cardResponse;
    logic [SLOTS-1:0]  slotIrq;
    logic [3:0]        unitNumber;
    logic [DATA_W-1:0] upstreamData;
    logic [DATA_W-1:0] cardSideData;
  } pin_in_s;

  typedef struct packed {
    pin_in_s           s1;
    pin_in_s           s2;
    phase_e            phase;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        unmask;
    logic [7:0]        pending;
    logic              irqReq;
    logic [SLOTS-1:0]  slotEnable;
    logic [7:0]        registerSelect;
    logic [DATA_W-1:0] upOut;
    logic              upOe;
    logic [DATA_W-1:0] cardOut;
    logic              cardOe;
    logic              upResp;
  } state_s;

  localparam state_s STATE_RST = '{phase: PH_IDLE, unmask: UNMASK_RST, default: '0};

endpackage : backplane_pkg

// ---- card_model.sv ----
`timescale 1ns/10ps
// function cards behind the slot enables; reply delay set by the bench
module card_model (
  input  wire logic        clk,
  input  wire logic [7:0]  slotEnable,
  input  wire logic        dataStrobeLine,
  input  wire logic        writeCycle,
  input  wire logic [3:0]  delay,
  input  wire logic [7:0]  setIrq,
  output logic             cardResponse,
  output logic      [15:0] cardData,
  output logic      [7:0]  irq
);
  logic [3:0] waitQ;
  initial begin
    cardResponse = 1'b0;
    cardData     = 16'h0000;
    irq          = 8'h00;
    waitQ        = 4'h0;
  end
  always @(posedge clk) begin
    irq <= irq | setIrq;
    if (dataStrobeLine && slotEnable != 8'h00) begin
      waitQ <= waitQ + 4'h1;
      if (waitQ >= delay) cardResponse <= 1'b1;
      if (waitQ == delay && !writeCycle) irq <= (irq | setIrq) & ~slotEnable;
    end else begin
      waitQ        <= 4'h0;
      cardResponse <= 1'b0;
    end
    // unselected card lines toggle so stale data never looks valid
    cardData <= (slotEnable != 8'h00 && !writeCycle) ? {8'hA5, slotEnable} : ~cardData;
  end
endmodule : card_model

// ---- backplane_slot_decode_irq_tb.sv ----
`timescale 1ns/10ps
module backplane_slot_decode_irq_tb;
  logic clk, rst_b, ce, as, ds, wr, card_response, upOe, cdOe, fir, prevResp, upstream_response;
  logic [3:0] unit, delay;
  logic [7:0] irqIn, setIrq, slotEnable, regSel, unmaskExp, irqExp;
  logic [15:0] upIn, upOut, cdIn, cdOut, d;
  logic [15:0] expQ[$];
  int seed, fail_count, checked;
  backplane_slot_decode_irq backplane_slot_decode_irq_i (.clk(clk), .rst_b(rst_b), .ce(ce),
    .unitSelect(unit), .addressStrobe(as), .dataStrobeLine(ds), .writeCycle(wr),
    .cardResponse(card_response), .slotInterruptIn(irqIn), .upstreamDataIn(upIn),
    .upstreamDataOut(upOut), .upstreamDataOe(upOe), .cardSideDataIn(cdIn),
    .cardSideDataOut(cdOut), .cardSideDataOe(cdOe), .upstreamResponse(upstream_response),
    .slotEnable(slotEnable), .registerSelect(regSel), .functionInterruptRequest(fir));
  card_model card_model_i (.clk(clk), .slotEnable(slotEnable), .dataStrobeLine(ds),
    .writeCycle(wr), .delay(delay), .setIrq(setIrq), .cardResponse(card_response),
    .cardData(cdIn), .irq(irqIn));
  always #12.5 clk = ~clk;
  task wrap_up;
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk
  // one bus cycle, entered just after a falling edge
  task cyc(input logic [15:0] a, input logic w, input logic [15:0] dw, input logic ans);
    int n;
    logic [7:0] en;
    en = (a[14:11] == unit && a[7:0] != 8'hFF) ? 8'h01 << a[10:8] : 8'h00;
    as = 1'b1;
    wr = 1'b1;
    upIn = a;
    repeat (4) @(negedge clk);
    as = 1'b0;
    repeat (4) @(negedge clk);
    chk("slotEnable", {8'h00, en}, {8'h00, slotEnable});
    chk("registerSelect", {8'h00, a[7:0]}, {8'h00, regSel});
    wr = w;
    upIn = w ? dw : ~a;
    ds = 1'b1;
    for (n = 0; n < (ans ? 40 : 8); n++) begin
      @(posedge clk);
      #1;
      if (upstream_response === 1'b1) break;
    end
    if (ans && n == 40) begin
      fail_count++;
      wrap_up();
    end
    if (ans && w && en != 8'h00) chk("cardSideDataOe", 16'h0001, {15'h0000, cdOe});
    if (ans && w && en != 8'h00) chk("cardSideDataOut", dw, cdOut);
    if (!ans) chk("upstreamOe", 16'h0000, {15'h0000, upOe});
    @(negedge clk) ds = 1'b0;
    repeat (4) @(negedge clk);
    chk("slotEnableHold", {8'h00, en}, {8'h00, slotEnable});
  endtask : cyc
  always @(negedge clk) begin
    if (upstream_response === 1'b1 && prevResp !== 1'b1 && upOe === 1'b1) begin
      if (expQ.size() == 0) begin
        fail_count++;
        $display("BAD upstreamDataOut exp none got %h", upOut);
      end else chk("upstreamDataOut", expQ.pop_front(), upOut);
    end
    prevResp = upstream_response;
  end
  initial begin
    seed = 1;
    clk = 1'b0;
    {rst_b, as, ds, wr, prevResp} = 5'h00;
    ce = 1'b1;
    upIn = 16'h0000;
    delay = 4'h0;
    setIrq = 8'h00;
    unit = 4'($random(seed));
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    unmaskExp = 8'($random(seed));
    cyc({1'b0, unit, 3'h0, 8'hFF}, 1'b1, {8'h00, unmaskExp}, 1'b1);
    irqExp = 8'($random(seed));
    setIrq = irqExp;
    @(negedge clk) setIrq = 8'h00;
    repeat (6) @(negedge clk);
    chk("functionInterruptRequest", {15'h0000, |(irqExp & unmaskExp)}, {15'h0000, fir});
    expQ.push_back({unmaskExp, irqExp & unmaskExp});
    cyc({1'b0, unit, 3'h5, 8'hFF}, 1'b0, 16'h0000, 1'b1);
    for (int s = 0; s < 8; s++) begin
      delay = s[0] ? 4'h5 : 4'h0;
      expQ.push_back({8'hA5, 8'h01 << s});
      cyc({1'b0, unit, 3'(s), 8'h00}, 1'b0, 16'h0000, 1'b1);
    end
    repeat (6) @(negedge clk);
    chk("functionInterruptRequest", 16'h0000, {15'h0000, fir});
    expQ.push_back({unmaskExp, 8'h00});
    cyc({1'b0, unit, 3'h0, 8'hFF}, 1'b0, 16'h0000, 1'b1);
    d = 16'($random(seed));
    cyc({1'b0, unit, 3'h3, 8'h12}, 1'b1, d, 1'b1);
    cyc({1'b0, unit + 4'h1, 3'h2, 8'h10}, 1'b0, 16'h0000, 1'b0);
    ce = 1'b0;
    setIrq = 8'hFF;
    @(negedge clk) setIrq = 8'h00;
    repeat (6) @(negedge clk);
    chk("frozenRequest", 16'h0000, {15'h0000, fir});
    ce = 1'b1;
    repeat (6) @(negedge clk);
    chk("resumedRequest", {15'h0000, |unmaskExp}, {15'h0000, fir});
    wrap_up();
  end
endmodule : backplane_slot_decode_irq_tb
